/* msc_host_model.sv */
// host controller model: select pin, data line pull and byte accesses
`timescale 1ns/1ps
module msc_host_model import msc_pkg::*; (
  input wire logic clk_i,
  input wire msc_rsp_t rsp_i,
  output msc_req_t req_o,
  output logic sel_n_o,
  output logic sel_drv_o,
  output logic sda_drive_o
);
  // --------------------------------------------------------------
  // host actions
  // --------------------------------------------------------------
  // start floating, so the module pull-up leaves it deselected
  initial begin
    req_o = '0;
    sel_n_o = 1'b1;
    sel_drv_o = 1'b0;
    sda_drive_o = 1'b0;
  end

  // a shared bus picks this module by pulling its select low
  task set_pins(input logic drv, input logic sel_n, input logic sda);
    @(negedge clk_i);
    sel_drv_o = drv;
    sel_n_o = sel_n;
    sda_drive_o = sda;
  endtask : set_pins

  // one byte; valid stands for exactly the take edge, answer sampled next cycle
  task access(input logic wr, input logic [7:0] a, input logic [7:0] wd,
              output logic got, output logic [7:0] rd);
    @(negedge clk_i);
    req_o = '{1'b1, wr, a, wd};
    @(negedge clk_i);
    got = rsp_i.valid;
    rd = rsp_i.data;
    req_o = '0;
  endtask : access

  // other status bits mean nothing until not-ready clears; poll is bounded
  task wait_ready(output logic ok);
    logic got;
    logic [7:0] rd;
    ok = 1'b0;
    for (int i = 0; i < 50 && !ok; i++) begin
      access(1'b0, ADDR_STATUS, 8'h00, got, rd);
      ok = got && !rd[STATUS_NOT_READY_BIT];
    end
  endtask : wait_ready
endmodule : msc_host_model

/* msc_pkg.sv */
// shared constants and carrier types of the module sideband control block
package msc_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int RESET_MIN_NS = 1000;
  localparam int INIT_NS = 2000;
  // least time rounds up to whole cycles
  localparam int RESET_MIN_CYC = (RESET_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int INIT_CYC = (INIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ----------------------------------------------------------------
  // management map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS = 8'h02;
  localparam logic [7:0] ADDR_LOS_FLAG = 8'h03;
  localparam logic [7:0] ADDR_TEMP_FLAG = 8'h06;
  localparam logic [7:0] ADDR_CTRL_POWER = 8'h5d;
  localparam logic [7:0] ADDR_MASK_LOS = 8'h64;
  localparam logic [7:0] ADDR_MASK_TEMP = 8'h67;

  // field positions
  localparam int STATUS_NOT_READY_BIT = 0;
  localparam int STATUS_INT_BIT = 1;
  localparam int TEMP_INIT_DONE_BIT = 0;
  localparam int POWER_OVR_BIT = 0;
  localparam int POWER_SET_BIT = 1;

  // values after reset
  localparam logic [7:0] MASK_LOS_RST = 8'h00;
  localparam logic [7:0] MASK_TEMP_RST = 8'h00;
  localparam logic [7:0] CTRL_POWER_RST = 8'h00;
  localparam logic [7:0] LOS_FLAG_RST = 8'h00;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MSC_ST_INIT = 2'b00,
    MSC_ST_RUN = 2'b01,
    MSC_ST_RESET = 2'b11
  } msc_state_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } msc_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } msc_rsp_t;

endpackage : msc_pkg

/* msc_sideband_control.sv */
// sideband pins and management-side state of a pluggable optical module
`timescale 1ns/1ps

module msc_sideband_control import msc_pkg::*; #(
  parameter int RESET_MIN_CYCLES = RESET_MIN_CYC,
  parameter int INIT_CYCLES = INIT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic module_select_n_i,
  input wire logic module_select_driven_i,
  input wire logic module_reset_n_i,
  input wire logic low_power_request_i,
  input wire logic [7:0] los_event_i,
  input wire msc_req_t req_i,
  input wire logic sda_drive_i,
  output msc_rsp_t rsp_o,
  output logic sda_o,
  output logic sda_oe_o,
  output logic intl_o,
  output logic intl_oe_o,
  output logic present_n_o,
  output logic low_power_o,
  output logic not_ready_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  msc_state_t st_q, st_d;
  logic [15:0] low_cnt_q, low_cnt_d;
  logic [15:0] init_cnt_q, init_cnt_d;
  logic [7:0] los_q, los_d;
  logic init_done_q, init_done_d;
  logic [7:0] mask_los_q, mask_los_d;
  logic [7:0] mask_temp_q, mask_temp_d;
  logic [7:0] ctrl_power_q, ctrl_power_d;
  msc_rsp_t rsp_d;
  logic sda_oe_d, intl_oe_d, low_power_d, not_ready_d;
  logic selected, pending, rd_hit;

  // flag pending after a read-clear still counts; set wins over clear
  function automatic logic [7:0] msc_flag_next(input logic [7:0] cur, input logic [7:0] set,
                                               input logic clr);
    return (clr ? 8'h00 : cur) | set;
  endfunction : msc_flag_next

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    // pull-up: a floating select reads high, so the module stays deselected
    selected = module_select_driven_i & ~module_select_n_i;
    rd_hit = req_i.valid & selected & ~req_i.write;
    // only unmasked latched sources may pull the interrupt line
    pending = |(los_q & ~mask_los_q) | (init_done_q & ~mask_temp_q[TEMP_INIT_DONE_BIT]);
    st_d = st_q;
    low_cnt_d = low_cnt_q;
    init_cnt_d = init_cnt_q;
    mask_los_d = mask_los_q;
    mask_temp_d = mask_temp_q;
    ctrl_power_d = ctrl_power_q;
    // latched sources clear on a read of their byte
    los_d = msc_flag_next(los_q, los_event_i, rd_hit && req_i.addr == ADDR_LOS_FLAG);
    init_done_d = (rd_hit && req_i.addr == ADDR_TEMP_FLAG) ? 1'b0 : init_done_q;
    rsp_d = '0;
    // glitch filter: count consecutive low cycles, saturating
    if (module_reset_n_i) begin
      low_cnt_d = 16'h0000;
    end else if (low_cnt_q < 16'(RESET_MIN_CYCLES)) begin
      low_cnt_d = low_cnt_q + 16'h0001;
    end
    case (st_q)
      MSC_ST_INIT: begin
        if (init_cnt_q >= 16'(INIT_CYCLES - 1)) begin
          st_d = MSC_ST_RUN;
          init_done_d = 1'b1;
        end else begin
          init_cnt_d = init_cnt_q + 16'h0001;
        end
      end
      MSC_ST_RUN: ;
      MSC_ST_RESET: begin
        if (module_reset_n_i) begin
          st_d = MSC_ST_INIT;
        end
      end
      default: st_d = MSC_ST_RESET;
    endcase
    // a short dip never reaches the limit and is ignored
    if (!module_reset_n_i && low_cnt_q == 16'(RESET_MIN_CYCLES - 1)) begin
      st_d = MSC_ST_RESET;
    end
    // register access, gated by select
    if (req_i.valid && selected && st_q != MSC_ST_RESET) begin
      if (req_i.write) begin
        case (req_i.addr)
          ADDR_MASK_LOS: mask_los_d = req_i.wdata;
          ADDR_MASK_TEMP: mask_temp_d = req_i.wdata;
          ADDR_CTRL_POWER: ctrl_power_d = req_i.wdata;
          default: ;
        endcase
      end else begin
        rsp_d.valid = 1'b1;
        case (req_i.addr)
          ADDR_STATUS: begin
            rsp_d.data[STATUS_NOT_READY_BIT] = st_q != MSC_ST_RUN;
            rsp_d.data[STATUS_INT_BIT] = ~intl_oe_o;
          end
          ADDR_LOS_FLAG: rsp_d.data = los_q;
          ADDR_TEMP_FLAG: rsp_d.data[TEMP_INIT_DONE_BIT] = init_done_q;
          ADDR_CTRL_POWER: rsp_d.data = ctrl_power_q;
          ADDR_MASK_LOS: rsp_d.data = mask_los_q;
          ADDR_MASK_TEMP: rsp_d.data = mask_temp_q;
          default: rsp_d.data = 8'h00;
        endcase
      end
    end
    // reset restores every settable byte and drops latched flags
    if (st_d == MSC_ST_RESET) begin
      mask_los_d = MASK_LOS_RST;
      mask_temp_d = MASK_TEMP_RST;
      ctrl_power_d = CTRL_POWER_RST;
      los_d = LOS_FLAG_RST;
      init_done_d = 1'b0;
      init_cnt_d = 16'h0000;
    end
    sda_oe_d = sda_drive_i & selected;
    intl_oe_d = pending;
    // software override of the pin, else the pin itself decides
    low_power_d = ctrl_power_q[POWER_OVR_BIT] ? ctrl_power_q[POWER_SET_BIT]
                                              : low_power_request_i;
    // host must treat status as stale until this drops
    not_ready_d = st_d != MSC_ST_RUN;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // power-up enters init, so the completion flag rises after insertion too
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= MSC_ST_INIT;
      low_cnt_q <= 16'h0000;
      init_cnt_q <= 16'h0000;
      los_q <= LOS_FLAG_RST;
      init_done_q <= 1'b0;
      mask_los_q <= MASK_LOS_RST;
      mask_temp_q <= MASK_TEMP_RST;
      ctrl_power_q <= CTRL_POWER_RST;
      rsp_o <= '0;
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
      intl_o <= 1'b0;
      intl_oe_o <= 1'b0;
      present_n_o <= 1'b0;
      low_power_o <= 1'b0;
      not_ready_o <= 1'b1;
    end else begin
      st_q <= st_d;
      low_cnt_q <= low_cnt_d;
      init_cnt_q <= init_cnt_d;
      los_q <= los_d;
      init_done_q <= init_done_d;
      mask_los_q <= mask_los_d;
      mask_temp_q <= mask_temp_d;
      ctrl_power_q <= ctrl_power_d;
      rsp_o <= rsp_d;
      sda_o <= 1'b0; // open drain: only the enable moves
      sda_oe_o <= sda_oe_d;
      intl_o <= 1'b0;
      intl_oe_o <= intl_oe_d;
      present_n_o <= 1'b0;
      low_power_o <= low_power_d;
      not_ready_o <= not_ready_d;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence read_selected_s;
    req_i.valid && !req_i.write && selected && st_q != MSC_ST_RESET;
  endsequence

  sequence init_finish_s;
    st_q == MSC_ST_INIT ##1 st_q == MSC_ST_RUN;
  endsequence

  select_answer_a: assert property (read_selected_s |=> rsp_o.valid)
    else $error("selected read got no answer");
  deselect_quiet_a: assert property (!selected |=> !sda_oe_o && !rsp_o.valid)
    else $error("deselected module touched the bus");
  pullup_select_a: assert property (!module_select_driven_i |=> !rsp_o.valid)
    else $error("floating select was taken as low");
  reset_defaults_a: assert property (st_q == MSC_ST_RESET |->
    mask_los_q == MASK_LOS_RST && mask_temp_q == MASK_TEMP_RST
    && ctrl_power_q == CTRL_POWER_RST)
    else $error("defaults not restored in reset");
  reset_filter_a: assert property ($rose(st_q == MSC_ST_RESET) |->
    $past(low_cnt_q) == 16'(RESET_MIN_CYCLES - 1) && !$past(module_reset_n_i))
    else $error("reset taken before minimum length");
  insert_done_a: assert property (init_finish_s |-> init_done_q ##1 !not_ready_o)
    else $error("init completion flag not raised");
  low_power_a: assert property (!ctrl_power_q[POWER_OVR_BIT] |=>
    low_power_o == $past(low_power_request_i))
    else $error("low-power output does not follow pin");
  int_drive_a: assert property (pending |=> intl_oe_o)
    else $error("interrupt not driven while pending");
  int_release_a: assert property (!pending |=> !intl_oe_o)
    else $error("interrupt held with no unmasked source");
  // a latched but masked source must leave the line released
  los_mask_a: assert property (los_q != 8'h00 && (los_q & ~mask_los_q) == 8'h00
    && !(init_done_q && !mask_temp_q[TEMP_INIT_DONE_BIT]) |=> !intl_oe_o)
    else $error("masked source drove the interrupt");
  // interrupt bit shows the pin level, so it reads 0 while the line is pulled
  status_word_a: assert property (read_selected_s ##0 req_i.addr == ADDR_STATUS |=>
    rsp_o.data[STATUS_NOT_READY_BIT] == ($past(st_q) != MSC_ST_RUN)
    && rsp_o.data[STATUS_INT_BIT] != $past(intl_oe_o))
    else $error("status word bits wrong");
  present_low_a: assert property (present_n_o == 1'b0)
    else $error("presence not low");

endmodule : msc_sideband_control

/* tb_top.sv */
// self-checking bench of the module sideband control block
`timescale 1ns/1ps
module tb_top;
  import msc_pkg::*;
  typedef struct packed {
    logic [7:0] los;
    logic ipre;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wd;
    logic [7:0] exp;
    logic ipost;
  } msc_row_t;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic clk_i, rst_n_i, mrst_n, lp_req, sel_n, sel_drv, sda_drv, ok;
  logic [7:0] los_ev;
  msc_req_t req;
  msc_rsp_t rsp;
  logic sda, sda_oe, intl, intl_oe, prs_n, lp_o, nrdy;
  int errors = 0;
  int n_checks = 0;
  // los pulse, line before access, access, answer, line after access
  msc_row_t rows [0:9] = '{
    '{8'h00, 1'b1, 1'b0, 8'h06, 8'h00, 8'h01, 1'b0},
    '{8'h00, 1'b0, 1'b0, 8'h02, 8'h00, 8'h02, 1'b0},
    '{8'h00, 1'b0, 1'b1, 8'h64, 8'h01, 8'h00, 1'b0},
    '{8'h01, 1'b0, 1'b0, 8'h03, 8'h00, 8'h01, 1'b0},
    '{8'h04, 1'b1, 1'b0, 8'h02, 8'h00, 8'h00, 1'b1},
    '{8'h00, 1'b1, 1'b0, 8'h03, 8'h00, 8'h04, 1'b0},
    '{8'h00, 1'b0, 1'b1, 8'h40, 8'h55, 8'h00, 1'b0},
    '{8'h00, 1'b0, 1'b0, 8'h40, 8'h00, 8'h00, 1'b0},
    '{8'h00, 1'b0, 1'b1, 8'h5d, 8'h03, 8'h00, 1'b0},
    '{8'h00, 1'b0, 1'b0, 8'h64, 8'h00, 8'h01, 1'b0}};

  // short counts keep the run brief; expectations use the same values
  msc_sideband_control #(.RESET_MIN_CYCLES(4), .INIT_CYCLES(4)) msc_sideband_control_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .module_select_n_i(sel_n),
    .module_select_driven_i(sel_drv), .module_reset_n_i(mrst_n),
    .low_power_request_i(lp_req), .los_event_i(los_ev), .req_i(req),
    .sda_drive_i(sda_drv), .rsp_o(rsp), .sda_o(sda), .sda_oe_o(sda_oe),
    .intl_o(intl), .intl_oe_o(intl_oe), .present_n_o(prs_n),
    .low_power_o(lp_o), .not_ready_o(nrdy));
  msc_host_model msc_host_model_i (
    .clk_i(clk_i), .rsp_i(rsp), .req_o(req), .sel_n_o(sel_n),
    .sel_drv_o(sel_drv), .sda_drive_o(sda_drv));

  initial clk_i = 1'b0;
  always #2 clk_i = ~clk_i;
  // ----------------------------------------------------------------
  // checking tasks
  // ----------------------------------------------------------------
  // widen a single bit on purpose so every compare runs at byte width
  function automatic logic [7:0] b8(input logic b);
    return {7'h00, b};
  endfunction : b8

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] wd,
                     input logic [7:0] exp, input logic ans);
    logic got;
    logic [7:0] rd;
    msc_host_model_i.access(wr, a, wd, got, rd);
    chk(b8(got), b8(ans));
    if (ans) chk(rd, exp);
  endtask : acc

  task end_sim;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim

  // whole run is under two hundred cycles; this is far beyond it
  initial begin
    #80000;
    errors++;
    end_sim();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n_i = 1'b0;
    mrst_n = 1'b1;
    lp_req = 1'b0;
    los_ev = 8'h00;
    repeat (5) @(negedge clk_i);
    chk(b8(nrdy), 8'h01);
    chk(b8(prs_n), 8'h00);
    rst_n_i = 1'b1;
    msc_host_model_i.set_pins(1'b1, 1'b0, 1'b0);
    msc_host_model_i.wait_ready(ok);
    chk(b8(ok), 8'h01);
    repeat (2) @(negedge clk_i);
    chk(b8(intl_oe), 8'h01);
    chk(b8(intl), 8'h00);
    chk(b8(sda), 8'h00);
    foreach (rows[i]) begin
      los_ev = rows[i].los;
      @(negedge clk_i) los_ev = 8'h00;
      repeat (2) @(negedge clk_i);
      chk(b8(intl_oe), b8(rows[i].ipre));
      acc(rows[i].wr, rows[i].addr, rows[i].wd, rows[i].exp, !rows[i].wr);
      repeat (2) @(negedge clk_i);
      chk(b8(intl_oe), b8(rows[i].ipost));
    end
    chk(b8(lp_o), 8'h01);
    acc(1'b1, ADDR_CTRL_POWER, 8'h00, 8'h00, 1'b0);
    lp_req = 1'b1;
    repeat (2) @(negedge clk_i);
    chk(b8(lp_o), 8'h01);
    lp_req = 1'b0;
    repeat (2) @(negedge clk_i);
    chk(b8(lp_o), 8'h00);
    // override with the set bit clear wins over a raised pin
    lp_req = 1'b1;
    acc(1'b1, ADDR_CTRL_POWER, 8'h01, 8'h00, 1'b0);
    repeat (2) @(negedge clk_i);
    chk(b8(lp_o), 8'h00);
    // deselected: no answer, no write; floating select: no answer; line released in both
    msc_host_model_i.set_pins(1'b1, 1'b1, 1'b1);
    acc(1'b0, ADDR_MASK_LOS, 8'h00, 8'h00, 1'b0);
    acc(1'b1, ADDR_MASK_LOS, 8'hff, 8'h00, 1'b0);
    chk(b8(sda_oe), 8'h00);
    msc_host_model_i.set_pins(1'b0, 1'b0, 1'b1);
    acc(1'b0, ADDR_MASK_LOS, 8'h00, 8'h00, 1'b0);
    chk(b8(sda_oe), 8'h00);
    msc_host_model_i.set_pins(1'b1, 1'b0, 1'b1);
    repeat (2) @(negedge clk_i);
    chk(b8(sda_oe), 8'h01);
    chk(b8(sda), 8'h00);
    msc_host_model_i.set_pins(1'b1, 1'b0, 1'b0);
    acc(1'b0, ADDR_MASK_LOS, 8'h00, 8'h01, 1'b1);
    // a three-cycle dip is filtered, an eight-cycle one resets
    mrst_n = 1'b0;
    repeat (3) @(negedge clk_i);
    mrst_n = 1'b1;
    acc(1'b0, ADDR_MASK_LOS, 8'h00, 8'h01, 1'b1);
    mrst_n = 1'b0;
    repeat (8) @(negedge clk_i);
    chk(b8(nrdy), 8'h01);
    acc(1'b0, ADDR_MASK_LOS, 8'h00, 8'h00, 1'b0);
    mrst_n = 1'b1;
    msc_host_model_i.wait_ready(ok);
    chk(b8(ok), 8'h01);
    acc(1'b0, ADDR_MASK_LOS, 8'h00, MASK_LOS_RST, 1'b1);
    acc(1'b0, ADDR_CTRL_POWER, 8'h00, CTRL_POWER_RST, 1'b1);
    chk(b8(lp_o), 8'h01);
    chk(b8(intl_oe), 8'h01);
    // masking init-done releases the line but the flag stays latched
    acc(1'b1, ADDR_MASK_TEMP, 8'h01, 8'h00, 1'b0);
    repeat (2) @(negedge clk_i);
    chk(b8(intl_oe), 8'h00);
    acc(1'b0, ADDR_MASK_TEMP, 8'h00, 8'h01, 1'b1);
    acc(1'b0, ADDR_TEMP_FLAG, 8'h00, 8'h01, 1'b1);
    end_sim();
  end
endmodule : tb_top
